// *** inc/svd_pkg.sv ***
// Purpose : Shared constants and types for the supply voltage detector control.
// Assumes : 125 MHz core clock, 8-bit register port.
// Notes   : Register offsets are word indices on the plain register port.

package svd_pkg;

    // ************************************************************
    // Register port
    // ************************************************************
    localparam int          ADDR_W       = 4;
    localparam int          DATA_W       = 8;
    localparam logic [3:0]  OFS_CONTROL  = 4'h0;
    localparam logic [3:0]  OFS_STATUS   = 4'h1;
    localparam logic [3:0]  OFS_MASK     = 4'h2;
    localparam logic [3:0]  OFS_MONITOR  = 4'h3;

    // ************************************************************
    // Control field positions and reset value
    // ************************************************************
    localparam int          POS_DIR      = 7;
    localparam int          POS_UNUSED   = 6;
    localparam int          POS_STABLE   = 5;
    localparam int          POS_ENABLE   = 4;
    localparam int          POS_LEVEL    = 0;
    localparam logic [7:0]  CONTROL_RST  = 8'h05;
    localparam logic [7:0]  CONTROL_WMSK = 8'h9F;
    localparam logic [3:0]  LEVEL_EXT    = 4'hF;

    // ************************************************************
    // Status and mask layout
    // ************************************************************
    localparam int          POS_EVENT    = 0;
    localparam logic [7:0]  STATUS_RST   = 8'h00;
    localparam logic [7:0]  MASK_RST     = 8'h00;

    // ************************************************************
    // Reference stabilisation time
    // ************************************************************
    localparam int          CLK_PERIOD_PS = 8000;
    localparam int          SETTLE_NS     = 20000;
    localparam int          SETTLE_CYC    = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
    localparam int          CNT_W         = 12;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic       dir;
        logic       unused;
        logic       stable;
        logic       enable;
        logic [3:0] level;
    } svd_control_type;

    typedef struct packed {
        logic       power_en;
        logic       ext_sel;
        logic [3:0] tap_sel;
    } svd_analog_type;

    typedef enum logic [1:0] {
        SVD_OFF,
        SVD_SETTLE,
        SVD_READY
    } svd_state_type;

endpackage

// *** core/svd_ctrl.sv ***
// Purpose : Control and status logic of a programmable supply voltage detector.
// Assumes : Comparator output is high while the monitored voltage is at or
//           above the trip level; reference ready comes from the analogue side.
// Notes   : Analogue inputs are asynchronous and pass two flip-flops first.

`timescale 1ns/10ps

// Behaviour
// - With direction select set, an event is flagged when the voltage is at or above the trip level.
// - With direction select clear, an event is flagged when the voltage is below the trip level.
// - Control bit 6 always reads zero and ignores writes.
// - The reference stable flag at bit 5 is read-only and events are raised only while it is one.
// - No event and no interrupt is produced until the stable flag is set after enabling.
// - The enable bit at bit 4 powers the detector and each fresh enable restarts the settling wait.
// - The four-bit trip level field selects sixteen settings, 0000 lowest and 1110 highest internal.
// - Trip level 1111 routes the external trip input to the comparator instead of a divider tap.
// - A qualified crossing sets the event flag and, if unmasked, raises the interrupt.
// - Reset returns the control register to its reset value with the detector off.
// - While enabled the detector keeps monitoring in sleep and an unmasked qualified crossing wakes the device.
module svd_ctrl (
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    // Register port
    input  wire logic [svd_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [svd_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [svd_pkg::DATA_W-1:0] reg_rdata,
    // Analogue side
    input  wire logic                       cmp_above,
    input  wire logic                       ref_ready,
    output svd_pkg::svd_analog_type         analog_ctrl,
    // System
    input  wire logic                       sleep_mode,
    output logic                            wake_req,
    output logic                            irq
);

    // ************************************************************
    // Declarations
    // ************************************************************
    svd_pkg::svd_control_type         control_r;
    svd_pkg::svd_control_type         control_nxt;
    logic [svd_pkg::DATA_W-1:0]       status_r;
    logic [svd_pkg::DATA_W-1:0]       status_nxt;
    logic [svd_pkg::DATA_W-1:0]       mask_r;
    logic [svd_pkg::DATA_W-1:0]       mask_nxt;
    logic [svd_pkg::DATA_W-1:0]       rdata_r;
    logic [svd_pkg::DATA_W-1:0]       rdata_nxt;
    logic [svd_pkg::DATA_W-1:0]       read_mux;
    svd_pkg::svd_state_type           state_r;
    svd_pkg::svd_state_type           state_nxt;
    logic [svd_pkg::CNT_W-1:0]        settle_cnt_r;
    logic [svd_pkg::CNT_W-1:0]        settle_cnt_nxt;
    svd_pkg::svd_analog_type          analog_r;
    svd_pkg::svd_analog_type          analog_nxt;
    logic                             wake_r;
    logic                             wake_nxt;
    logic                             cmp_meta_r;
    logic                             cmp_sync_r;
    logic                             rdy_meta_r;
    logic                             rdy_sync_r;
    logic                             wr_control;
    logic                             wr_status;
    logic                             wr_mask;
    logic                             rd_hit;
    logic                             enable_rise;
    logic                             settle_done;
    logic                             stable;
    logic                             event_cond;
    logic                             event_set;
    logic [svd_pkg::DATA_W-1:0]       event_vec;
    logic [svd_pkg::DATA_W-1:0]       pending;

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic addr_hit(
        input logic [svd_pkg::ADDR_W-1:0] addr,
        input logic [svd_pkg::ADDR_W-1:0] ofs
    );
        addr_hit = (addr == ofs);
    endfunction

    function automatic logic [svd_pkg::DATA_W-1:0] sticky_update(
        input logic [svd_pkg::DATA_W-1:0] cur,
        input logic [svd_pkg::DATA_W-1:0] set,
        input logic                       clr_en,
        input logic [svd_pkg::DATA_W-1:0] clr
    );
        logic [svd_pkg::DATA_W-1:0] keep;
        keep          = clr_en ? (cur & ~clr) : cur;
        sticky_update = keep | set;
    endfunction

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cmp_meta_r <= 1'b0;
            cmp_sync_r <= 1'b0;
            rdy_meta_r <= 1'b0;
            rdy_sync_r <= 1'b0;
        end else begin
            cmp_meta_r <= cmp_above;
            cmp_sync_r <= cmp_meta_r;
            rdy_meta_r <= ref_ready;
            rdy_sync_r <= rdy_meta_r;
        end
    end

    // ************************************************************
    // Address decode
    // ************************************************************
    assign wr_control = reg_wr && addr_hit(reg_addr, svd_pkg::OFS_CONTROL);
    assign wr_status  = reg_wr && addr_hit(reg_addr, svd_pkg::OFS_STATUS);
    assign wr_mask    = reg_wr && addr_hit(reg_addr, svd_pkg::OFS_MASK);
    assign rd_hit     = reg_rd;

    // ************************************************************
    // Control register
    // ************************************************************
    always_comb begin
        control_nxt = control_r;
        if (wr_control) begin
            control_nxt.dir    = reg_wdata[svd_pkg::POS_DIR];
            control_nxt.enable = reg_wdata[svd_pkg::POS_ENABLE];
            control_nxt.level  = reg_wdata[svd_pkg::POS_LEVEL +: 4];
        end
        control_nxt.unused = 1'b0;
        control_nxt.stable = stable;
    end

    assign enable_rise = control_nxt.enable && !control_r.enable;

    // ************************************************************
    // Settling sequencer
    // ************************************************************
    assign settle_done = (settle_cnt_r ==
                          svd_pkg::SETTLE_CYC[svd_pkg::CNT_W-1:0]);

    always_comb begin
        state_nxt      = state_r;
        settle_cnt_nxt = settle_cnt_r;
        case (state_r)
            svd_pkg::SVD_OFF: begin
                settle_cnt_nxt = '0;
                if (control_r.enable) begin
                    state_nxt = svd_pkg::SVD_SETTLE;
                end
            end
            svd_pkg::SVD_SETTLE: begin
                if (!settle_done) begin
                    settle_cnt_nxt = settle_cnt_r + 1'b1;
                end
                if (settle_done && rdy_sync_r) begin
                    state_nxt = svd_pkg::SVD_READY;
                end
            end
            svd_pkg::SVD_READY: begin
                if (!rdy_sync_r) begin
                    state_nxt = svd_pkg::SVD_SETTLE;
                end
            end
            default: begin
                state_nxt      = svd_pkg::SVD_OFF;
                settle_cnt_nxt = '0;
            end
        endcase
        if (!control_r.enable || enable_rise) begin
            state_nxt      = svd_pkg::SVD_OFF;
            settle_cnt_nxt = '0;
        end
    end

    assign stable = (state_r == svd_pkg::SVD_READY) && control_r.enable;

    // ************************************************************
    // Event detection
    // ************************************************************
    assign event_cond = control_r.dir ? cmp_sync_r
                                      : !cmp_sync_r;
    assign event_set  = stable && control_r.stable && event_cond;
    assign event_vec  = {{(svd_pkg::DATA_W-1){1'b0}}, event_set};

    // ************************************************************
    // Status and mask
    // ************************************************************
    assign status_nxt = sticky_update(status_r, event_vec,
                                      wr_status, reg_wdata);
    assign mask_nxt   = wr_mask ? (reg_wdata & 8'h01) : mask_r;
    assign pending    = status_r & mask_r;

    // ************************************************************
    // Analogue controls and wake
    // ************************************************************
    always_comb begin
        analog_nxt.power_en = control_r.enable;
        analog_nxt.ext_sel  = (control_r.level == svd_pkg::LEVEL_EXT);
        analog_nxt.tap_sel  = control_r.level;
    end

    assign wake_nxt = sleep_mode && control_r.enable && (|pending);

    // ************************************************************
    // Read path
    // ************************************************************
    always_comb begin
        read_mux = '0;
        case (reg_addr)
            svd_pkg::OFS_CONTROL: read_mux = control_r;
            svd_pkg::OFS_STATUS:  read_mux = status_r;
            svd_pkg::OFS_MASK:    read_mux = mask_r;
            svd_pkg::OFS_MONITOR: read_mux = {4'h0, rdy_sync_r, cmp_sync_r,
                                              state_r};
            default:              read_mux = '0;
        endcase
    end

    assign rdata_nxt = rd_hit ? read_mux : '0;

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            control_r <= svd_pkg::svd_control_type'(svd_pkg::CONTROL_RST);
            status_r  <= svd_pkg::STATUS_RST;
            mask_r    <= svd_pkg::MASK_RST;
        end else begin
            control_r <= control_nxt;
            status_r  <= status_nxt;
            mask_r    <= mask_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_r      <= svd_pkg::SVD_OFF;
            settle_cnt_r <= '0;
        end else begin
            state_r      <= state_nxt;
            settle_cnt_r <= settle_cnt_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            analog_r <= '0;
            wake_r   <= 1'b0;
            rdata_r  <= '0;
        end else begin
            analog_r <= analog_nxt;
            wake_r   <= wake_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign reg_rdata   = rdata_r;
    assign analog_ctrl = analog_r;
    assign wake_req    = wake_r;
    assign irq         = |pending;

endmodule // svd_ctrl

// *** test/svd_analog_model.sv ***
// Purpose : Comparator and divider model facing the detector control.
// Assumes : Supply and trip level are given in tap units.
// Notes   : Equality counts as above; reference ready lags power-up.
`timescale 1ns/10ps
module svd_analog_model #(parameter int REF_DLY = 400) (
    // Control from the detector
    input  wire svd_pkg::svd_analog_type analog_ctrl,
    // Stimulus
    input  wire logic [3:0]              supply_lvl,
    input  wire logic                    ext_above,
    // Comparator outputs
    output logic                         cmp_above,
    output logic                         ref_ready
);
    // ********
    // Comparator and reference
    // ********
    assign cmp_above = analog_ctrl.ext_sel ? ext_above : (supply_lvl >= analog_ctrl.tap_sel);
    initial ref_ready = 1'h0;
    always @(analog_ctrl.power_en) begin
        ref_ready = 1'h0;
        if (analog_ctrl.power_en) begin
            ref_ready <= #REF_DLY 1'h1;
        end
    end
endmodule // svd_analog_model

// *** test/svd_ctrl_assertions.sv ***
// Purpose : Port checks of the detector control.
// Assumes : One clock domain, synchronous active-low reset.
// Notes   : Bound into every detector control instance.
`timescale 1ns/10ps
module svd_ctrl_assertions (
    // Clock, reset and register port
    input wire logic                       core_clk,
    input wire logic                       rst_b,
    input wire logic [svd_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [svd_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                       reg_wr,
    input wire logic                       reg_rd,
    input wire logic [svd_pkg::DATA_W-1:0] reg_rdata,
    // Analogue and system
    input wire svd_pkg::svd_analog_type    analog_ctrl,
    input wire logic                       sleep_mode,
    input wire logic                       wake_req,
    input wire logic                       irq
);
    // ********
    // Helpers and checks
    // ********
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic [11:0] on_cnt_r;
    wire         ctl_wr = reg_wr && reg_addr == svd_pkg::OFS_CONTROL;
    wire         ctl_rd = reg_rd && reg_addr == svd_pkg::OFS_CONTROL;
    wire [3:0]   wr_lvl = reg_wdata[3:0];
    wire         wr_en  = reg_wdata[4];
    always_ff @(posedge core_clk) begin
        if (!rst_b || !analog_ctrl.power_en) begin
            on_cnt_r <= 12'h000;
        end else if (on_cnt_r != 12'hFFF) begin
            on_cnt_r <= on_cnt_r + 12'h001;
        end
    end
    chk_bit6_zero: assert property ($past(ctl_rd) |-> !reg_rdata[6])
        else $error("control bit 6 read as one");
    chk_stable_enable: assert property ($past(ctl_rd) && reg_rdata[5] |-> reg_rdata[4])
        else $error("stable flag set while disabled");
    chk_irq_cause: assert property ($rose(irq) |-> analog_ctrl.power_en || $past(reg_wr))
        else $error("interrupt rose with detector off");
    chk_settle_gate: assert property ($rose(irq) && !$past(reg_wr) |-> on_cnt_r >= 12'h9C0)
        else $error("interrupt rose before settling");
    chk_wake_cause: assert property (wake_req |-> $past(sleep_mode) && $past(irq))
        else $error("wake without sleep or pending event");
    chk_wake_set: assert property (sleep_mode && irq && analog_ctrl.power_en &&
        !$past(reg_wr) |=> wake_req) else $error("no wake in sleep");
    chk_tap_follow: assert property (ctl_wr |=> ##1 analog_ctrl.tap_sel == $past(wr_lvl, 2))
        else $error("tap select not applied");
    chk_ext_follow: assert property (ctl_wr |=> ##1
        analog_ctrl.ext_sel == ($past(wr_lvl, 2) == 4'hF)) else $error("external select wrong");
    chk_power_follow: assert property (ctl_wr |=> ##1 analog_ctrl.power_en == $past(wr_en, 2))
        else $error("power enable not applied");
    cover property ($rose(irq));
    cover property (wake_req);
    cover property ($past(ctl_rd) && reg_rdata[5]);
endmodule // svd_ctrl_assertions
bind svd_ctrl svd_ctrl_assertions u_svd_ctrl_assertions (.core_clk(core_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .analog_ctrl(analog_ctrl), .sleep_mode(sleep_mode),
    .wake_req(wake_req), .irq(irq));

// *** test/svd_ctrl_tb.sv ***
// Purpose : Self-checking bench of the detector control.
// Assumes : Model stands in for comparator and divider.
// Notes   : One settling wait is about 2500 cycles.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module svd_ctrl_tb;
    // ********
    // Signals, design and model
    // ********
    logic                    core_clk   = 1'h0;
    logic                    rst_b      = 1'h0;
    logic [3:0]              reg_addr   = 4'h0;
    logic [7:0]              reg_wdata  = 8'h00;
    logic                    reg_wr     = 1'h0;
    logic                    reg_rd     = 1'h0;
    logic                    sleep_mode = 1'h0;
    logic [3:0]              supply_lvl = 4'h0;
    logic                    ext_above  = 1'h0;
    logic [7:0]              reg_rdata, d;
    logic                    cmp_above, ref_ready, wake_req, irq;
    svd_pkg::svd_analog_type analog_ctrl;
    int                      err_count  = 0;
    int                      n_compared = 0;
    // Control, supply, external, expected event
    logic [13:0] rows [10] = '{{8'h95, 4'h5, 1'h0, 1'h1}, {8'h96, 4'h5, 1'h0, 1'h0},
        {8'h16, 4'h5, 1'h0, 1'h1}, {8'h14, 4'h5, 1'h0, 1'h0}, {8'h90, 4'h0, 1'h0, 1'h1},
        {8'h9E, 4'hF, 1'h0, 1'h1}, {8'h9E, 4'hD, 1'h0, 1'h0}, {8'h9F, 4'h0, 1'h1, 1'h1},
        {8'h9F, 4'hF, 1'h0, 1'h0}, {8'h1F, 4'hF, 1'h0, 1'h1}};
    always #4 core_clk = ~core_clk;
    svd_ctrl u_svd_ctrl (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cmp_above(cmp_above), .ref_ready(ref_ready), .analog_ctrl(analog_ctrl),
        .sleep_mode(sleep_mode), .wake_req(wake_req), .irq(irq));
    svd_analog_model u_svd_analog_model (.analog_ctrl(analog_ctrl), .supply_lvl(supply_lvl),
        .ext_above(ext_above), .cmp_above(cmp_above), .ref_ready(ref_ready));
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 v = reg_rdata;
    endtask
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
        rd(a, d);
        `CHK("register", e, d)
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'h1;
        chk_rd(4'h7, 8'h00);
        wr(svd_pkg::OFS_MASK, 8'h01);
        supply_lvl <= 4'h5;
        wr(svd_pkg::OFS_CONTROL, 8'hF0);
        chk_rd(svd_pkg::OFS_CONTROL, 8'h90);
        repeat (200) @(posedge core_clk);
        chk_rd(svd_pkg::OFS_STATUS, 8'h00);
        `CHK("irq", 1'h0, irq)
        d = 8'h00;
        for (int i = 0; i < 1500 && d[5] !== 1'h1; i++) begin
            rd(svd_pkg::OFS_CONTROL, d);
        end
        `CHK("stable", 8'hB0, d)
        repeat (6) @(posedge core_clk);
        chk_rd(svd_pkg::OFS_STATUS, 8'h01);
        `CHK("irq", 1'h1, irq)
        @(posedge core_clk);
        sleep_mode <= 1'h1;
        repeat (3) @(posedge core_clk);
        `CHK("wake", 1'h1, wake_req)
        sleep_mode <= 1'h0;
        wr(svd_pkg::OFS_MASK, 8'h00);
        #1;
        `CHK("irq", 1'h0, irq)
        wr(svd_pkg::OFS_MASK, 8'h01);
        foreach (rows[i]) begin
            @(posedge core_clk);
            supply_lvl <= rows[i][5:2];
            ext_above <= rows[i][1];
            wr(svd_pkg::OFS_CONTROL, rows[i][13:6]);
            repeat (8) @(posedge core_clk);
            wr(svd_pkg::OFS_STATUS, 8'h01);
            repeat (8) @(posedge core_clk);
            chk_rd(svd_pkg::OFS_STATUS, {7'h00, rows[i][0]});
            `CHK("irq", rows[i][0], irq)
            `CHK("analog", {1'h1, rows[i][9:6] == 4'hF, rows[i][9:6]}, analog_ctrl)
            chk_rd(svd_pkg::OFS_CONTROL, rows[i][13:6] | 8'h20);
        end
        wr(svd_pkg::OFS_CONTROL, 8'h05);
        wr(svd_pkg::OFS_STATUS, 8'h01);
        repeat (20) @(posedge core_clk);
        chk_rd(svd_pkg::OFS_CONTROL, 8'h05);
        wr(svd_pkg::OFS_CONTROL, 8'h95);
        repeat (100) @(posedge core_clk);
        chk_rd(svd_pkg::OFS_CONTROL, 8'h95);
        chk_rd(svd_pkg::OFS_STATUS, 8'h00);
        @(posedge core_clk);
        rst_b <= 1'h0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'h1;
        chk_rd(svd_pkg::OFS_CONTROL, 8'h05);
        chk_rd(svd_pkg::OFS_MASK, 8'h00);
        `CHK("analog", 6'h05, analog_ctrl)
        final_report();
    end
endmodule // svd_ctrl_tb
